// ==== src/eslirq_pkg.sv ====
/*
 * constants for the event status latch and interrupt block: register
 * offsets, bit positions, writable masks and reset values.
 * assumes a byte-wide register port with 12-bit addresses.
 */
// Operation
// - mode bit 7 latches power-detect error
// - mode bit 5 latches blanking done
// - mode bit 3 latches alignment locked
// - mode bit 2 latches alignment rotated
// - mode bit 1 latches outside-window alignment
// - mode bit 0 latches alignment tripped
// - mode bits reset zero; 6,4 read-only
// - status bit 7 shows calibration passed
// - status bit 6 shows calibration failed
// - status bit 5 shows converter loop lost
// - status bit 4 shows converter loop locked
// - status bit 3 shows link loop lost
// - latch only on rising edge, then hold
// - writing one clears a latched bit
// - bits 4,3 of preceding mode register
package eslirq_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int NUM_EVT = 11;

    localparam logic [11:0] CAL_MODE_ADDR = 12'h01F;
    localparam logic [11:0] CH1_MODE_ADDR = 12'h022;
    localparam logic [11:0] CAL_STATUS_ADDR = 12'h023;
    localparam logic [11:0] CH1_STATUS_ADDR = 12'h026;

    // channel-1 mode and status bit positions
    localparam int CH1_PDP_BIT = 7;
    localparam int CH1_BLANK_BIT = 5;
    localparam int CH1_LOCK_BIT = 3;
    localparam int CH1_ROT_BIT = 2;
    localparam int CH1_WIN_BIT = 1;
    localparam int CH1_TRIP_BIT = 0;

    // calibration and clock loop bit positions
    localparam int CAL_PASS_BIT = 7;
    localparam int CAL_FAIL_BIT = 6;
    localparam int CONV_LOST_BIT = 5;
    localparam int CONV_LOCK_BIT = 4;
    localparam int LINK_LOST_BIT = 3;

    localparam logic [7:0] CH1_MASK = 8'hAF;
    localparam logic [7:0] CAL_MASK = 8'hF8;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h00;
endpackage : eslirq_pkg

// ==== src/eslirq_cell.sv ====
/*
 * one event status cell: live or latched reporting of one source.
 * assumes the source is synchronous to clk.
 */
`timescale 1ns/100ps
module eslirq_cell (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // event side
    input wire logic source,
    input wire logic latch_mode,
    input wire logic clear,
    // status side
    output logic status,
    output logic held
);
    logic prev;
    logic next_prev;
    logic next_held;
    logic rise;

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        rise = source & ~prev;
        next_prev = source;
        if (!latch_mode) begin
            // parked clear so enabling latch mode starts clean
            next_held = 1'b0;
        end else if (rise) begin
            next_held = 1'b1; // set beats clear
        end else if (clear) begin
            next_held = 1'b0;
        end else begin
            next_held = held;
        end
        status = latch_mode ? held : source;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prev <= 1'b0;
            held <= 1'b0;
        end else begin
            prev <= next_prev;
            held <= next_held;
        end
    end

    ////////////////////////////////////////////////////////////////////
    AST_RISE_LATCHES: assert property (@(posedge clk) disable iff (!rst_n)
        latch_mode && source && !prev && $past(latch_mode) |=> held)
        else $error("rising source did not latch");

    AST_HOLD_NO_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
        held && latch_mode && !clear ##1 latch_mode |-> held)
        else $error("latched bit dropped without clear");

    AST_CLEAR_WORKS: assert property (@(posedge clk) disable iff (!rst_n)
        held && clear && !(source && !prev) |=> !held)
        else $error("write one did not clear");

    AST_LIVE_FOLLOWS: assert property (@(posedge clk) disable iff (!rst_n)
        !latch_mode |-> status == source ##1 !held)
        else $error("live status differs from source");
endmodule : eslirq_cell

// ==== src/eslirq_top.sv ====
/*
 * event status latch and interrupt reporting for channel-1 events and
 * calibration / clock loop events, reached over the internal register
 * port of the serial control interface.
 * assumes event sources and register strobes synchronous to clk.
 */
`timescale 1ns/100ps
module eslirq_top (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire logic [11:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // channel-1 event sources
    input wire logic ch1_power_detect_error,
    input wire logic ch1_blanking_done,
    input wire logic ch1_alignment_locked,
    input wire logic ch1_alignment_rotated,
    input wire logic ch1_alignment_outside_window,
    input wire logic ch1_alignment_tripped,
    // calibration and clock loop sources
    input wire logic calibration_passed,
    input wire logic calibration_failed,
    input wire logic conv_clock_loop_lost,
    input wire logic conv_clock_loop_locked,
    input wire logic link_clock_loop_lost,
    // interrupt
    output logic irq_n
);
    logic [7:0] ch1_mode;
    logic [7:0] cal_mode;
    logic [7:0] next_ch1_mode;
    logic [7:0] next_cal_mode;
    logic [7:0] next_rdata;
    logic next_irq_n;
    logic [10:0] src;
    logic [10:0] mode;
    logic [10:0] clr;
    logic [10:0] stat;
    logic [10:0] held;
    logic [7:0] ch1_status;
    logic [7:0] cal_status;
    logic wr_ch1_status;
    logic wr_cal_status;

    ////////////////////////////////////////////////////////////////////
    // event vectors: 0..5 channel 1, 6..10 calibration and loops
    always_comb begin
        src = {link_clock_loop_lost, conv_clock_loop_locked,
               conv_clock_loop_lost, calibration_failed,
               calibration_passed, ch1_alignment_tripped,
               ch1_alignment_outside_window, ch1_alignment_rotated,
               ch1_alignment_locked, ch1_blanking_done,
               ch1_power_detect_error};
        mode = {cal_mode[eslirq_pkg::LINK_LOST_BIT],
                cal_mode[eslirq_pkg::CONV_LOCK_BIT],
                cal_mode[eslirq_pkg::CONV_LOST_BIT],
                cal_mode[eslirq_pkg::CAL_FAIL_BIT],
                cal_mode[eslirq_pkg::CAL_PASS_BIT],
                ch1_mode[eslirq_pkg::CH1_TRIP_BIT],
                ch1_mode[eslirq_pkg::CH1_WIN_BIT],
                ch1_mode[eslirq_pkg::CH1_ROT_BIT],
                ch1_mode[eslirq_pkg::CH1_LOCK_BIT],
                ch1_mode[eslirq_pkg::CH1_BLANK_BIT],
                ch1_mode[eslirq_pkg::CH1_PDP_BIT]};
        wr_ch1_status = reg_wr && reg_addr == eslirq_pkg::CH1_STATUS_ADDR;
        wr_cal_status = reg_wr && reg_addr == eslirq_pkg::CAL_STATUS_ADDR;
        // only ones clear; zeros do nothing
        clr = {{5{wr_cal_status}} & {
                   reg_wdata[eslirq_pkg::LINK_LOST_BIT],
                   reg_wdata[eslirq_pkg::CONV_LOCK_BIT],
                   reg_wdata[eslirq_pkg::CONV_LOST_BIT],
                   reg_wdata[eslirq_pkg::CAL_FAIL_BIT],
                   reg_wdata[eslirq_pkg::CAL_PASS_BIT]},
               {6{wr_ch1_status}} & {
                   reg_wdata[eslirq_pkg::CH1_TRIP_BIT],
                   reg_wdata[eslirq_pkg::CH1_WIN_BIT],
                   reg_wdata[eslirq_pkg::CH1_ROT_BIT],
                   reg_wdata[eslirq_pkg::CH1_LOCK_BIT],
                   reg_wdata[eslirq_pkg::CH1_BLANK_BIT],
                   reg_wdata[eslirq_pkg::CH1_PDP_BIT]}};
    end

    ////////////////////////////////////////////////////////////////////
    genvar gi;
    generate
        for (gi = 0; gi < eslirq_pkg::NUM_EVT; gi = gi + 1) begin : g_evt
            eslirq_cell u_cell (
                .clk(clk),
                .rst_n(rst_n),
                .source(src[gi]),
                .latch_mode(mode[gi]),
                .clear(clr[gi]),
                .status(stat[gi]),
                .held(held[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // read views; reserved positions read zero
    always_comb begin
        ch1_status = 8'h00;
        ch1_status[eslirq_pkg::CH1_PDP_BIT] = stat[0];
        ch1_status[eslirq_pkg::CH1_BLANK_BIT] = stat[1];
        ch1_status[eslirq_pkg::CH1_LOCK_BIT] = stat[2];
        ch1_status[eslirq_pkg::CH1_ROT_BIT] = stat[3];
        ch1_status[eslirq_pkg::CH1_WIN_BIT] = stat[4];
        ch1_status[eslirq_pkg::CH1_TRIP_BIT] = stat[5];
        cal_status = 8'h00;
        cal_status[eslirq_pkg::CAL_PASS_BIT] = stat[6];
        cal_status[eslirq_pkg::CAL_FAIL_BIT] = stat[7];
        cal_status[eslirq_pkg::CONV_LOST_BIT] = stat[8];
        cal_status[eslirq_pkg::CONV_LOCK_BIT] = stat[9];
        cal_status[eslirq_pkg::LINK_LOST_BIT] = stat[10];
    end

    ////////////////////////////////////////////////////////////////////
    // mode registers, read data and interrupt
    always_comb begin
        next_ch1_mode = ch1_mode;
        next_cal_mode = cal_mode;
        if (reg_wr && reg_addr == eslirq_pkg::CH1_MODE_ADDR) begin
            // reserved bits 6 and 4 masked off
            next_ch1_mode = reg_wdata & eslirq_pkg::CH1_MASK;
        end
        if (reg_wr && reg_addr == eslirq_pkg::CAL_MODE_ADDR) begin
            next_cal_mode = reg_wdata & eslirq_pkg::CAL_MASK;
        end
        next_rdata = reg_rdata;
        if (reg_rd) begin
            case (reg_addr)
                eslirq_pkg::CH1_MODE_ADDR: next_rdata = ch1_mode;
                eslirq_pkg::CAL_MODE_ADDR: next_rdata = cal_mode;
                eslirq_pkg::CAL_STATUS_ADDR: next_rdata = cal_status;
                eslirq_pkg::CH1_STATUS_ADDR: next_rdata = ch1_status;
                default: next_rdata = 8'h00;
            endcase
        end
        // held is only ever set in latch mode, so no extra gating
        next_irq_n = ~|held;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ch1_mode <= eslirq_pkg::MODE_RESET;
            cal_mode <= eslirq_pkg::MODE_RESET;
            reg_rdata <= 8'h00;
            irq_n <= 1'b1;
        end else begin
            ch1_mode <= next_ch1_mode;
            cal_mode <= next_cal_mode;
            reg_rdata <= next_rdata;
            irq_n <= next_irq_n;
        end
    end

    ////////////////////////////////////////////////////////////////////
    AST_IRQ_TRACKS: assert property (@(posedge clk) disable iff (!rst_n)
        ##1 irq_n == ~|$past(held))
        else $error("interrupt does not reflect latched bits");

    AST_IRQ_ON_EVENT: assert property (@(posedge clk) disable iff (!rst_n)
        ch1_mode[eslirq_pkg::CH1_PDP_BIT] && $rose(ch1_power_detect_error)
        && $stable(ch1_mode) |-> ##2 !irq_n)
        else $error("power error event did not assert interrupt");

    AST_CH1_RSVD: assert property (@(posedge clk) disable iff (!rst_n)
        (ch1_mode & ~eslirq_pkg::CH1_MASK) == 8'h00)
        else $error("reserved mode bits set");

    AST_MODE_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
        reg_wr && reg_addr == eslirq_pkg::CH1_MODE_ADDR
        |=> ch1_mode == ($past(reg_wdata) & eslirq_pkg::CH1_MASK))
        else $error("mode write not stored");

    AST_ZERO_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
        wr_cal_status && reg_wdata == 8'h00 |-> clr == 11'h000)
        else $error("zero write produced a clear");

    AST_CAL_LIVE: assert property (@(posedge clk) disable iff (!rst_n)
        !cal_mode[eslirq_pkg::CAL_PASS_BIT]
        |-> cal_status[eslirq_pkg::CAL_PASS_BIT] == calibration_passed)
        else $error("calibration pass not live");

    AST_READ_MODE: assert property (@(posedge clk) disable iff (!rst_n)
        reg_rd && reg_addr == eslirq_pkg::CAL_MODE_ADDR && !reg_wr
        |=> reg_rdata == $past(cal_mode))
        else $error("mode readback wrong");

    AST_RESET_MODE: assert property (@(posedge clk)
        !rst_n |=> ch1_mode == 8'h00 && cal_mode == 8'h00 && irq_n)
        else $error("reset values wrong");

    AST_RESET_RDATA: assert property (@(posedge clk)
        !rst_n |=> reg_rdata == 8'h00)
        else $error("read data not cleared by reset");

    ////////////////////////////////////////////////////////////////////
    // register port checks
    AST_CAL_MODE_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
        reg_wr && reg_addr == eslirq_pkg::CAL_MODE_ADDR
        |=> cal_mode == ($past(reg_wdata) & eslirq_pkg::CAL_MASK))
        else $error("calibration mode write not stored");

    AST_CAL_RSVD: assert property (@(posedge clk) disable iff (!rst_n)
        (cal_mode & ~eslirq_pkg::CAL_MASK) == 8'h00)
        else $error("reserved calibration mode bits set");

    AST_RDATA_HOLDS: assert property (@(posedge clk) disable iff (!rst_n)
        !reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without a read");

    AST_UNMAPPED_READ: assert property (@(posedge clk) disable iff (!rst_n)
        reg_rd && reg_addr != eslirq_pkg::CH1_MODE_ADDR
        && reg_addr != eslirq_pkg::CAL_MODE_ADDR
        && reg_addr != eslirq_pkg::CAL_STATUS_ADDR
        && reg_addr != eslirq_pkg::CH1_STATUS_ADDR |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");

    AST_CAL_STAT_READ: assert property (@(posedge clk) disable iff (!rst_n)
        reg_rd && reg_addr == eslirq_pkg::CAL_STATUS_ADDR
        |=> reg_rdata == $past(cal_status))
        else $error("calibration status readback wrong");

    AST_CH1_STAT_READ: assert property (@(posedge clk) disable iff (!rst_n)
        reg_rd && reg_addr == eslirq_pkg::CH1_STATUS_ADDR
        |=> reg_rdata == $past(ch1_status))
        else $error("channel status readback wrong");

    AST_STAT_RSVD: assert property (@(posedge clk) disable iff (!rst_n)
        (cal_status & ~eslirq_pkg::CAL_MASK) == 8'h00
        && (ch1_status & ~eslirq_pkg::CH1_MASK) == 8'h00)
        else $error("reserved status bits set");

    ////////////////////////////////////////////////////////////////////
    // live reporting, one per source except calibration passed (checked above)
    AST_PDP_LIVE: assert property (@(posedge clk) disable iff (!rst_n)
        !ch1_mode[eslirq_pkg::CH1_PDP_BIT]
        |-> ch1_status[eslirq_pkg::CH1_PDP_BIT] == ch1_power_detect_error)
        else $error("power error not live");

    AST_BLANK_LIVE: assert property (@(posedge clk) disable iff (!rst_n)
        !ch1_mode[eslirq_pkg::CH1_BLANK_BIT]
        |-> ch1_status[eslirq_pkg::CH1_BLANK_BIT] == ch1_blanking_done)
        else $error("blanking done not live");

    AST_LOCK_LIVE: assert property (@(posedge clk) disable iff (!rst_n)
        !ch1_mode[eslirq_pkg::CH1_LOCK_BIT]
        |-> ch1_status[eslirq_pkg::CH1_LOCK_BIT] == ch1_alignment_locked)
        else $error("alignment locked not live");

    AST_ROT_LIVE: assert property (@(posedge clk) disable iff (!rst_n)
        !ch1_mode[eslirq_pkg::CH1_ROT_BIT]
        |-> ch1_status[eslirq_pkg::CH1_ROT_BIT] == ch1_alignment_rotated)
        else $error("alignment rotated not live");

    AST_WIN_LIVE: assert property (@(posedge clk) disable iff (!rst_n)
        !ch1_mode[eslirq_pkg::CH1_WIN_BIT]
        |-> ch1_status[eslirq_pkg::CH1_WIN_BIT]
            == ch1_alignment_outside_window)
        else $error("outside window not live");

    AST_TRIP_LIVE: assert property (@(posedge clk) disable iff (!rst_n)
        !ch1_mode[eslirq_pkg::CH1_TRIP_BIT]
        |-> ch1_status[eslirq_pkg::CH1_TRIP_BIT] == ch1_alignment_tripped)
        else $error("alignment tripped not live");

    AST_FAIL_LIVE: assert property (@(posedge clk) disable iff (!rst_n)
        !cal_mode[eslirq_pkg::CAL_FAIL_BIT]
        |-> cal_status[eslirq_pkg::CAL_FAIL_BIT] == calibration_failed)
        else $error("calibration fail not live");

    AST_LOST_LIVE: assert property (@(posedge clk) disable iff (!rst_n)
        !cal_mode[eslirq_pkg::CONV_LOST_BIT]
        |-> cal_status[eslirq_pkg::CONV_LOST_BIT] == conv_clock_loop_lost)
        else $error("converter loop lost not live");

    AST_LOCKED_LIVE: assert property (@(posedge clk) disable iff (!rst_n)
        !cal_mode[eslirq_pkg::CONV_LOCK_BIT]
        |-> cal_status[eslirq_pkg::CONV_LOCK_BIT] == conv_clock_loop_locked)
        else $error("converter loop lock not live");

    AST_LINK_LIVE: assert property (@(posedge clk) disable iff (!rst_n)
        !cal_mode[eslirq_pkg::LINK_LOST_BIT]
        |-> cal_status[eslirq_pkg::LINK_LOST_BIT] == link_clock_loop_lost)
        else $error("link loop lost not live");

    ////////////////////////////////////////////////////////////////////
    // latching, clearing and the interrupt line
    AST_IRQ_SET: assert property (@(posedge clk) disable iff (!rst_n)
        held != 11'h000 |=> !irq_n)
        else $error("latched bit without interrupt");

    AST_IRQ_RELEASE: assert property (@(posedge clk) disable iff (!rst_n)
        held == 11'h000 |=> irq_n)
        else $error("interrupt without latched bit");

    AST_MODES_OFF_IRQ: assert property (@(posedge clk) disable iff (!rst_n)
        ch1_mode == 8'h00 && cal_mode == 8'h00 |-> ##2 irq_n)
        else $error("interrupt with every source live");

    // set beats clear, so a write can never swallow a fresh event
    AST_SET_BEATS_CLR: assert property (@(posedge clk) disable iff (!rst_n)
        mode[6] && $rose(calibration_passed) && clr[6] |=> held[6])
        else $error("rise lost to a clear in the same cycle");

    AST_FRESH_EDGE: assert property (@(posedge clk) disable iff (!rst_n)
        !cal_mode[eslirq_pkg::CAL_PASS_BIT] ##1
        cal_mode[eslirq_pkg::CAL_PASS_BIT] && $stable(calibration_passed)
        |=> !held[6])
        else $error("mode switch alone latched a bit");

    AST_W1C_CAL: assert property (@(posedge clk) disable iff (!rst_n)
        wr_cal_status && reg_wdata[eslirq_pkg::CAL_FAIL_BIT] && held[7]
        && !$rose(calibration_failed) |=> !held[7])
        else $error("calibration fail clear ignored");
endmodule : eslirq_top

// ==== tb/eslirq_host.sv ====
/*
 * host model: byte reads and writes on the register port, and an
 * interrupt service that acknowledges every latched status bit.
 * assumes the bench calls one task at a time.
 */
`timescale 1ns/100ps
module eslirq_host (
    // clock
    input wire logic clk,
    // register port
    output logic [11:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    // interrupt
    input wire logic irq_n
);
    initial begin
        reg_addr = 12'h000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clk);
        #1;
        reg_wr = 1'b0;
        // idle lines flip so stale data is never mistaken for a request
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask : wr
    task automatic rd(input logic [11:0] a, output logic [7:0] d);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clk);
        #1;
        d = reg_rdata;
        reg_rd = 1'b0;
        reg_addr = ~a;
    endtask : rd
    // acknowledge: every one read back is written back as one
    task automatic service();
        logic [7:0] v;
        if (irq_n === 1'b0) begin
            rd(eslirq_pkg::CAL_STATUS_ADDR, v);
            wr(eslirq_pkg::CAL_STATUS_ADDR, v);
            rd(eslirq_pkg::CH1_STATUS_ADDR, v);
            wr(eslirq_pkg::CH1_STATUS_ADDR, v);
        end
    endtask : service
endmodule : eslirq_host

// ==== tb/eslirq_top_tb.sv ====
/*
 * bench for the event status latch block: integer model of modes,
 * held bits and sources, compared at each check_all register read and irq_n.
 * assumes the host model in eslirq_host.
 */
`timescale 1ns/100ps
module eslirq_top_tb;
    logic clk, rst_n, reg_wr, reg_rd, irq_n;
    logic [11:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, rv, s1, sc;
    int n_fail, cmp_count, seed, r, i;
    int m1, mc, h1, hc, o1, oc;
    always #5 clk = ~clk;
    eslirq_top i_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .ch1_power_detect_error(s1[7]),
        .ch1_blanking_done(s1[5]), .ch1_alignment_locked(s1[3]),
        .ch1_alignment_rotated(s1[2]),
        .ch1_alignment_outside_window(s1[1]),
        .ch1_alignment_tripped(s1[0]), .calibration_passed(sc[7]),
        .calibration_failed(sc[6]), .conv_clock_loop_lost(sc[5]),
        .conv_clock_loop_locked(sc[4]), .link_clock_loop_lost(sc[3]),
        .irq_n(irq_n));
    eslirq_host i_host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .irq_n(irq_n));
    ////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        if (n_fail == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    function automatic logic [7:0] stat(int m, int h, int s, int k);
        return 8'((m & h | ~m & s) & k);
    endfunction : stat
    task automatic wr(input int a, input int d);
        case (a)
            'h022: begin m1 = d & 'hAF; h1 &= m1; end
            'h01F: begin mc = d & 'hF8; hc &= mc; end
            'h026: h1 &= ~d;
            'h023: hc &= ~d;
            default: ;
        endcase
        i_host.wr(12'(a), 8'(d));
        repeat (3) @(posedge clk);
    endtask : wr
    task automatic set_src(input int n1, input int nc);
        h1 |= n1 & ~o1 & m1;
        hc |= nc & ~oc & mc;
        o1 = n1 & 'hAF;
        oc = nc & 'hF8;
        @(posedge clk);
        #1;
        s1 = 8'(o1);
        sc = 8'(oc);
        repeat (3) @(posedge clk);
    endtask : set_src
    task automatic check_all();
        i_host.rd(eslirq_pkg::CH1_MODE_ADDR, rv);
        chk(rv, 8'(m1));
        i_host.rd(eslirq_pkg::CAL_MODE_ADDR, rv);
        chk(rv, 8'(mc));
        i_host.rd(eslirq_pkg::CAL_STATUS_ADDR, rv);
        chk(rv, stat(mc, hc, oc, 'hF8));
        chk(rv & 8'h18, stat(mc, hc, oc, 'h18));
        i_host.rd(eslirq_pkg::CH1_STATUS_ADDR, rv);
        chk(rv, stat(m1, h1, o1, 'hAF));
        chk(rv & 8'h0F, stat(m1, h1, o1, 'h0F));
        i_host.rd(12'h0A5, rv);
        chk(rv, 8'h00);
        chk({7'h00, irq_n}, {7'h00, (m1 & h1 | mc & hc) == 0});
    endtask : check_all
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (100000) @(posedge clk);
        n_fail++;
        close_out();
    end
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        s1 = 8'h00;
        sc = 8'h00;
        seed = 27424;
        {n_fail, cmp_count, m1, mc, h1, hc, o1, oc} = '0;
        repeat (16) @(posedge clk);
        #1;
        rst_n = 1'b1;
        check_all();
        wr('h022, 'hFF); // reserved bits stay zero
        wr('h01F, 'hFF);
        check_all();
        // each source: rise, fall, write with only its bit zero, then one write
        for (i = 0; i < 8; i++) begin
            set_src(1 << i, 1 << i);
            set_src(0, 0);
            wr('h026, ~(1 << i));
            wr('h023, ~(1 << i));
            check_all();
            wr('h026, 1 << i);
            wr('h023, 1 << i);
            check_all();
        end
        for (i = 0; i < 80; i++) begin
            r = $random(seed);
            case (r[2:0])
                3'h0: wr('h022, $random(seed));
                3'h1: wr('h01F, $random(seed));
                3'h5: wr('h026, $random(seed));
                3'h6: wr('h023, $random(seed));
                3'h7: begin
                    i_host.service();
                    h1 = 0;
                    hc = 0;
                    repeat (3) @(posedge clk);
                end
                default: set_src($random(seed), $random(seed));
            endcase
            check_all();
        end
        // rise and its clear write on one edge: the bits stay set
        set_src(0, 0);
        wr('h01F, 'hF8);
        fork
            i_host.wr(eslirq_pkg::CAL_STATUS_ADDR, 8'hF8);
            begin
                @(posedge clk);
                #1;
                sc = 8'hF8;
            end
        join
        oc = 'hF8;
        hc = 'hF8;
        repeat (3) @(posedge clk);
        check_all();
        // second reset in mid-run with sources still high
        @(posedge clk);
        #1;
        rst_n = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        rst_n = 1'b1;
        {m1, mc, h1, hc} = '0;
        check_all();
        close_out();
    end
endmodule : eslirq_top_tb
